/* design/dsu_dual_serial.sv */
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module dsu_dual_serial
   import dsu_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       sys_rst,
   // register port
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrStb,
   input  wire logic       regRdStb,
   output logic      [7:0] regRdData,
   // baud sources, one-cycle overflow pulses
   input  wire logic       timer1Ovf,
   input  wire logic       timer2Ovf,
   // serial pins, per channel
   input  wire logic [1:0] serialInPin,
   output logic      [1:0] serialInPinOut,
   output logic      [1:0] serialInPinOe,
   output logic      [1:0] serialOutPin,
   // interrupt requests
   output logic      [1:0] txIrq,
   output logic      [1:0] rxIrq
);
   import dsu_pkg::*;

   typedef struct packed {
      dsu_chan_t [1:0] ch;
      logic      [3:0] clkSel;
      logic      [1:0] inA;
      logic      [1:0] inB;
      logic      [1:0] inC;
      logic      [1:0] inLvl;
      logic      [7:0] rdData;
   } dsu_state_all_t;

   dsu_state_all_t st_ff;
   dsu_state_all_t nxt_st;

   // =====================================================
   // helpers
   function automatic logic [3:0] dsu_frame_bits(input logic [1:0] m);
      if (m == DSU_MODE_SHIFT) begin
         return DSU_BITS8;
      end else if (m[0] == 1'b1 && m[1] == 1'b0) begin
         return DSU_BITS10;
      end
      return DSU_BITS10 + 4'h1;
   endfunction

   // 16x tick for one direction of one channel
   function automatic logic dsu_tick(input logic [1:0] m, input logic t2sel,
                                     input logic osc);
      if (m == DSU_MODE_SHIFT || m == DSU_MODE_FIX9) begin
         return osc;
      end
      return t2sel ? timer2Ovf : timer1Ovf;
   endfunction

   logic [1:0] m;
   logic       txTick;
   logic       rxTick;
   logic       oscTx;
   logic       oscRx;
   logic       sel;
   logic [3:0] base;
   logic       wrBuf;
   logic       wrCtl;
   logic       wrSt;
   logic       rdBuf;
   logic       inBit;
   logic [3:0] nBits;

   always_comb begin
      nxt_st = st_ff;
      m = 2'h0;
      txTick = 1'b0;
      rxTick = 1'b0;
      oscTx = 1'b0;
      oscRx = 1'b0;
      sel = 1'b0;
      base = 4'h0;
      wrBuf = 1'b0;
      wrCtl = 1'b0;
      wrSt = 1'b0;
      rdBuf = 1'b0;
      inBit = 1'b0;
      nBits = 4'h0;
      // three-stage pin sampling, level moves when last two agree
      // the first stage may be metastable, so only the last two feed the level
      nxt_st.inA = serialInPin;
      nxt_st.inB = st_ff.inA;
      nxt_st.inC = st_ff.inB;
      for (int i = 0; i < 2; i++) begin
         if (st_ff.inB[i] == st_ff.inC[i]) begin
            nxt_st.inLvl[i] = st_ff.inC[i];
         end
      end
      if (regWrStb && regAddr == DSU_OFF_CLKSEL) begin
         nxt_st.clkSel = regWrData[3:0];
      end
      nxt_st.rdData = 8'h00;
      if (regRdStb && regAddr == DSU_OFF_CLKSEL) begin
         nxt_st.rdData = {4'h0, st_ff.clkSel};
      end
      for (int c = 0; c < 2; c++) begin
         base = (c == 0) ? 4'h0 : DSU_CHAN_STEP;
         m = {st_ff.ch[c].ctrl[DSU_CTL_MODE1], st_ff.ch[c].ctrl[DSU_CTL_MODE0]};
         nBits = dsu_frame_bits(m);
         wrBuf = regWrStb && regAddr == base + DSU_OFF_BUF;
         wrCtl = regWrStb && regAddr == base + DSU_OFF_CTRL;
         wrSt = regWrStb && regAddr == base + DSU_OFF_STAT;
         rdBuf = regRdStb && regAddr == base + DSU_OFF_BUF;
         inBit = st_ff.inLvl[c];
         // =====================================================
         // fixed oscillator dividers, osc/16 in mode 0, osc/32 in mode 2 via 16x tick
         nxt_st.ch[c].txDiv = st_ff.ch[c].txDiv + 5'h01;
         if (m == DSU_MODE_SHIFT) begin
            // two ticks per bit: shift clock low half, then high half
            oscTx = st_ff.ch[c].txDiv == DSU_HALF_M0 - 5'h01;
         end else begin
            oscTx = st_ff.ch[c].txDiv[0];
         end
         if (oscTx && m == DSU_MODE_SHIFT) begin
            nxt_st.ch[c].txDiv = 5'h00;
         end else if (m != DSU_MODE_SHIFT && st_ff.ch[c].txDiv >= DSU_OSC_DIV_M2 - 5'h01) begin
            nxt_st.ch[c].txDiv = 5'h00;
         end
         nxt_st.ch[c].rxDiv = st_ff.ch[c].rxDiv + 5'h01;
         oscRx = (m != DSU_MODE_SHIFT) && st_ff.ch[c].rxDiv[0];
         if (st_ff.ch[c].rxDiv >= DSU_OSC_DIV_M2 - 5'h01) begin
            nxt_st.ch[c].rxDiv = 5'h00;
         end
         sel = (c == 0) ? st_ff.clkSel[DSU_CS_T0] : st_ff.clkSel[DSU_CS_T1];
         txTick = (m == DSU_MODE_SHIFT) ? oscTx : dsu_tick(m, sel, oscTx);
         sel = (c == 0) ? st_ff.clkSel[DSU_CS_R0] : st_ff.clkSel[DSU_CS_R1];
         rxTick = dsu_tick(m, sel, oscRx);

         // =====================================================
         // software writes first, hardware sets below win
         if (wrCtl) begin
            nxt_st.ch[c].ctrl = regWrData;
            nxt_st.ch[c].ctrl[DSU_CTL_TXDONE] = st_ff.ch[c].ctrl[DSU_CTL_TXDONE]
                                                & regWrData[DSU_CTL_TXDONE];
            nxt_st.ch[c].ctrl[DSU_CTL_RXDONE] = st_ff.ch[c].ctrl[DSU_CTL_RXDONE]
                                                & regWrData[DSU_CTL_RXDONE];
            nxt_st.ch[c].ctrl[DSU_CTL_RX9] = st_ff.ch[c].ctrl[DSU_CTL_RX9];
         end
         if (wrSt) begin
            nxt_st.ch[c].stat = st_ff.ch[c].stat & regWrData[3:0];
         end

         // =====================================================
         // transmitter: holding register plus shifter
         if (wrBuf) begin
            nxt_st.ch[c].txHold = regWrData;
            nxt_st.ch[c].txFull = 1'b1;
            if (!st_ff.ch[c].txBusy) begin
               nxt_st.ch[c].ctrl[DSU_CTL_TXDONE] = 1'b1;
            end
         end
         if (txTick && st_ff.ch[c].txBusy) begin
            nxt_st.ch[c].txPh = st_ff.ch[c].txPh + 4'h1;
            if (m == DSU_MODE_SHIFT) begin
               // shift clock low in first half, data steady over rising edge
               nxt_st.ch[c].sclk = st_ff.ch[c].txPh[0];
               if (st_ff.ch[c].txPh[0]) begin
                  nxt_st.ch[c].txShift = {1'b1, st_ff.ch[c].txShift[9:1]};
                  nxt_st.ch[c].txCnt = st_ff.ch[c].txCnt + 4'h1;
                  nxt_st.ch[c].rxShift = {1'b0, inBit, st_ff.ch[c].rxShift[7:1]};
               end
            end else if (st_ff.ch[c].txPh == DSU_OVS_LAST) begin
               nxt_st.ch[c].txCnt = st_ff.ch[c].txCnt + 4'h1;
               // ninth bit read live as it goes out
               if (st_ff.ch[c].txCnt == DSU_BITS8 && nBits != DSU_BITS10) begin
                  nxt_st.ch[c].txOut = st_ff.ch[c].ctrl[DSU_CTL_TX9];
               end else if (st_ff.ch[c].txCnt >= DSU_BITS8) begin
                  nxt_st.ch[c].txOut = 1'b1;
               end else begin
                  nxt_st.ch[c].txOut = st_ff.ch[c].txShift[0];
                  nxt_st.ch[c].txShift = {1'b1, st_ff.ch[c].txShift[9:1]};
               end
            end
         end
         if (st_ff.ch[c].txBusy && st_ff.ch[c].txCnt == nBits - 4'h1 + (m == DSU_MODE_SHIFT ? 4'h1 : 4'h0)
             && (m == DSU_MODE_SHIFT || (txTick && st_ff.ch[c].txPh == DSU_OVS_LAST))) begin
            // a mode 0 reception ends here too, but it sent nothing
            if (m != DSU_MODE_SHIFT || st_ff.ch[c].rxOe) begin
               nxt_st.ch[c].ctrl[DSU_CTL_TXDONE] = 1'b1;
            end
            nxt_st.ch[c].txBusy = 1'b0;
            nxt_st.ch[c].txOut = 1'b1;
            nxt_st.ch[c].sclk = 1'b1;
            if (m == DSU_MODE_SHIFT) begin
               nxt_st.ch[c].rxOe = 1'b0;
               // the drive enable tells a mode 0 send from a mode 0 reception
               if (!st_ff.ch[c].rxOe) begin
                  nxt_st.ch[c].rxBuf = st_ff.ch[c].rxShift[7:0];
                  nxt_st.ch[c].ctrl[DSU_CTL_RXDONE] = 1'b1;
               end
            end
         end else if (!st_ff.ch[c].txBusy && st_ff.ch[c].txFull && !wrBuf) begin
            // back to back load keeps the line packed
            nxt_st.ch[c].txBusy = 1'b1;
            nxt_st.ch[c].txFull = 1'b0;
            nxt_st.ch[c].txCnt = 4'h0;
            nxt_st.ch[c].txPh = 4'h0;
            nxt_st.ch[c].txShift = {2'h3, st_ff.ch[c].txHold};
            nxt_st.ch[c].txOut = (m == DSU_MODE_SHIFT) ? 1'b1 : 1'b0;
            nxt_st.ch[c].rxOe = m == DSU_MODE_SHIFT;
            nxt_st.ch[c].rxOut = st_ff.ch[c].txHold[0];
         end
         // data moves while the shift clock is low, so it stands over the rising edge
         if (m == DSU_MODE_SHIFT && st_ff.ch[c].txBusy && txTick
             && !st_ff.ch[c].txPh[0]) begin
            nxt_st.ch[c].rxOut = st_ff.ch[c].txShift[0];
         end
         // =====================================================
         // mode 0 receive: shift in with dummy ones when enabled and flag clear
         if (m == DSU_MODE_SHIFT && !st_ff.ch[c].txBusy && !st_ff.ch[c].txFull
             && st_ff.ch[c].ctrl[DSU_CTL_RXEN] && !st_ff.ch[c].ctrl[DSU_CTL_RXDONE]
             && !wrBuf && !wrCtl) begin
            nxt_st.ch[c].txBusy = 1'b1;
            nxt_st.ch[c].txCnt = 4'h0;
            nxt_st.ch[c].txPh = 4'h0;
            nxt_st.ch[c].txShift = 10'h3FF;
            nxt_st.ch[c].rxOe = 1'b0;
         end

         // =====================================================
         // asynchronous receiver
         if (m != DSU_MODE_SHIFT && rxTick) begin
            nxt_st.ch[c].rxPh = st_ff.ch[c].rxPh + 4'h1;
            case (st_ff.ch[c].rxSt)
               DSU_IDLE: begin
                  nxt_st.ch[c].rxPh = 4'h0;
                  if (!inBit && st_ff.ch[c].ctrl[DSU_CTL_RXEN]) begin
                     nxt_st.ch[c].rxSt = DSU_START;
                     nxt_st.ch[c].rxAllZero = 1'b1;
                  end
               end
               DSU_START: begin
                  if (st_ff.ch[c].rxPh == DSU_OVS_MID) begin
                     if (inBit) begin
                        nxt_st.ch[c].rxSt = DSU_IDLE;
                     end else begin
                        nxt_st.ch[c].rxSt = DSU_DATA;
                        nxt_st.ch[c].rxPh = 4'h0;
                        nxt_st.ch[c].rxCnt = 4'h0;
                     end
                  end
               end
               DSU_DATA: begin
                  if (st_ff.ch[c].rxPh == DSU_OVS_LAST) begin
                     nxt_st.ch[c].rxShift = {inBit, st_ff.ch[c].rxShift[8:1]};
                     nxt_st.ch[c].rxAllZero = st_ff.ch[c].rxAllZero & ~inBit;
                     nxt_st.ch[c].rxCnt = st_ff.ch[c].rxCnt + 4'h1;
                     if (st_ff.ch[c].rxCnt == nBits - 4'h3) begin
                        nxt_st.ch[c].rxSt = DSU_STOP;
                     end
                  end
               end
               DSU_STOP: begin
                  if (st_ff.ch[c].rxPh == DSU_OVS_LAST) begin
                     nxt_st.ch[c].rxSt = DSU_IDLE;
                     if (st_ff.ch[c].rxAllZero && !inBit) begin
                        nxt_st.ch[c].stat[DSU_ST_BRK] = 1'b1;
                     end
                     if (!inBit) begin
                        nxt_st.ch[c].stat[DSU_ST_FRM] = 1'b1;
                     end
                     // overrun keeps the older character, the new one is dropped
                     if (st_ff.ch[c].ctrl[DSU_CTL_RXDONE]) begin
                        nxt_st.ch[c].stat[DSU_ST_OVR] = 1'b1;
                     end else begin
                        nxt_st.ch[c].ctrl[DSU_CTL_RXDONE] = 1'b1;
                        if (nBits == DSU_BITS10) begin
                           nxt_st.ch[c].rxBuf = st_ff.ch[c].rxShift[8:1];
                           nxt_st.ch[c].ctrl[DSU_CTL_RX9] = inBit;
                        end else begin
                           nxt_st.ch[c].rxBuf = st_ff.ch[c].rxShift[7:0];
                           nxt_st.ch[c].ctrl[DSU_CTL_RX9] = st_ff.ch[c].rxShift[8];
                        end
                     end
                  end
               end
               default: nxt_st.ch[c].rxSt = DSU_IDLE;
            endcase
         end
         if (m == DSU_MODE_SHIFT) begin
            nxt_st.ch[c].rxSt = DSU_IDLE;
         end
         // =====================================================
         // summary follows the three error flags
         nxt_st.ch[c].stat[DSU_ST_ANY] = |nxt_st.ch[c].stat[3:1];

         // read data stand one slot after the strobe, zero otherwise
         if (regRdStb && regAddr == base + DSU_OFF_CTRL) begin
            nxt_st.rdData = st_ff.ch[c].ctrl;
         end
         if (regRdStb && regAddr == base + DSU_OFF_STAT) begin
            nxt_st.rdData = {4'h0, st_ff.ch[c].stat};
         end
         if (rdBuf) begin
            nxt_st.rdData = st_ff.ch[c].rxBuf;
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff <= '0;
         for (int c = 0; c < 2; c++) begin
            st_ff.ch[c].txOut <= 1'b1;
            st_ff.ch[c].sclk <= 1'b1;
            st_ff.ch[c].rxSt <= DSU_IDLE;
         end
         // pins idle high, so no false start bit after reset
         st_ff.inA <= 2'h3;
         st_ff.inB <= 2'h3;
         st_ff.inC <= 2'h3;
         st_ff.inLvl <= 2'h3;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // =====================================================
   // outputs
   always_comb begin
      regRdData = st_ff.rdData;
      for (int c = 0; c < 2; c++) begin
         serialOutPin[c] = (st_ff.ch[c].ctrl[DSU_CTL_MODE1:DSU_CTL_MODE0] == DSU_MODE_SHIFT)
                           ? st_ff.ch[c].sclk : st_ff.ch[c].txOut;
         serialInPinOut[c] = st_ff.ch[c].rxOut;
         serialInPinOe[c] = st_ff.ch[c].rxOe;
         txIrq[c] = st_ff.ch[c].ctrl[DSU_CTL_TXDONE];
         rxIrq[c] = st_ff.ch[c].ctrl[DSU_CTL_RXDONE];
      end
   end
endmodule
`default_nettype wire

/* design/dsu_pkg.sv */
package dsu_pkg;
   // =====================================================
   // register offsets, per channel base
   localparam logic [3:0] DSU_OFF_CTRL   = 4'h0;
   localparam logic [3:0] DSU_OFF_STAT   = 4'h1;
   localparam logic [3:0] DSU_OFF_BUF    = 4'h2;
   localparam logic [3:0] DSU_OFF_CLKSEL = 4'h8;
   localparam logic [3:0] DSU_CHAN_STEP  = 4'h4;
   // =====================================================
   // channel_control fields
   localparam int DSU_CTL_RXDONE = 0;
   localparam int DSU_CTL_TXDONE = 1;
   localparam int DSU_CTL_RX9    = 2;
   localparam int DSU_CTL_TX9    = 3;
   localparam int DSU_CTL_RXEN   = 4;
   localparam int DSU_CTL_MODE0  = 6;
   localparam int DSU_CTL_MODE1  = 7;
   // channel_error_status fields
   localparam int DSU_ST_ANY     = 0;
   localparam int DSU_ST_OVR     = 1;
   localparam int DSU_ST_BRK     = 2;
   localparam int DSU_ST_FRM     = 3;
   // clock select fields: chan0 rx, chan0 tx, chan1 rx, chan1 tx
   localparam int DSU_CS_R0 = 0;
   localparam int DSU_CS_T0 = 1;
   localparam int DSU_CS_R1 = 2;
   localparam int DSU_CS_T1 = 3;
   // =====================================================
   // timing
   localparam logic [4:0] DSU_OSC_DIV_M0 = 5'h10;
   localparam logic [4:0] DSU_OSC_DIV_M2 = 5'h02;
   localparam logic [4:0] DSU_HALF_M0    = 5'h08;
   localparam logic [3:0] DSU_OVS_LAST   = 4'hF;
   localparam logic [3:0] DSU_OVS_MID    = 4'h7;
   localparam logic [3:0] DSU_BITS8      = 4'h8;
   localparam logic [3:0] DSU_BITS9      = 4'h9;
   localparam logic [3:0] DSU_BITS10     = 4'hA;
   localparam logic [1:0] DSU_MODE_SHIFT = 2'h0;
   localparam logic [1:0] DSU_MODE_FIX9  = 2'h2;
   typedef enum {DSU_IDLE, DSU_START, DSU_DATA, DSU_STOP} dsu_state_t;
   typedef struct packed {
      logic [7:0]  ctrl;
      logic [3:0]  stat;
      logic [7:0]  rxBuf;
      logic [7:0]  txHold;
      logic        txFull;
      logic        txBusy;
      logic [9:0]  txShift;
      logic [3:0]  txCnt;
      logic [3:0]  txPh;
      logic [4:0]  txDiv;
      logic        txOut;
      logic        sclk;
      dsu_state_t  rxSt;
      logic [3:0]  rxPh;
      logic [3:0]  rxCnt;
      logic [8:0]  rxShift;
      logic        rxAllZero;
      logic [4:0]  rxDiv;
      logic        rxOe;
      logic        rxOut;
   } dsu_chan_t;
endpackage

/* tb/dsu_dual_serial_props.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// port checks of the dual serial block
module dsu_dual_serial_props
   import dsu_pkg::*;
(
   // clock and reset
   input wire logic       clock,
   input wire logic       sys_rst,
   // register port
   input wire logic [3:0] regAddr,
   input wire logic       regWrStb,
   input wire logic       regRdStb,
   input wire logic [7:0] regRdData,
   // pins and requests
   input wire logic [1:0] serialInPinOe,
   input wire logic [1:0] serialOutPin,
   input wire logic [1:0] txIrq,
   input wire logic [1:0] rxIrq
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   logic unmapped;
   logic isStat;
   logic isCtrl;
   assign unmapped = (regAddr[1:0] == 2'h3 && !regAddr[3]) || regAddr > 4'h8;
   assign isStat = regAddr == DSU_OFF_STAT || regAddr == DSU_OFF_STAT + DSU_CHAN_STEP;
   assign isCtrl = regAddr == DSU_OFF_CTRL || regAddr == DSU_OFF_CTRL + DSU_CHAN_STEP;
   chk_rd_quiet: assert property (
      !$past(regRdStb) |-> regRdData == 8'h00) else $error("read data outside slot");
   chk_unmapped_zero: assert property (
      $past(regRdStb && unmapped) |-> regRdData == 8'h00) else $error("unmapped read not zero");
   chk_stat_summary: assert property (
      $past(regRdStb && isStat) |-> regRdData[DSU_ST_ANY] == |regRdData[3:1])
      else $error("summary bit wrong");
   chk_break_frame: assert property (
      $past(regRdStb && isStat) && regRdData[DSU_ST_BRK] |-> regRdData[DSU_ST_FRM])
      else $error("break without frame error");
   chk_ctrl_flags: assert property (
      $past(regRdStb && isCtrl) |-> regRdData[1:0] == ($past(regAddr[2]) ?
         {$past(txIrq[1]), $past(rxIrq[1])} : {$past(txIrq[0]), $past(rxIrq[0])}))
      else $error("control flags differ from request lines");
   chk_tx_clear: assert property (
      $fell(txIrq[0]) |-> $past(regWrStb && regAddr == DSU_OFF_CTRL))
      else $error("tx request fell without write");
   chk_rx_clear: assert property (
      $fell(rxIrq[1]) |-> $past(regWrStb && regAddr == DSU_OFF_CTRL + DSU_CHAN_STEP))
      else $error("rx request fell without write");
   chk_idle_lines: assert property (
      $fell(sys_rst) |-> serialOutPin == 2'h3 && serialInPinOe == 2'h0)
      else $error("lines not idle after reset");
endmodule
bind dsu_dual_serial dsu_dual_serial_props u_props (
   .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrStb(regWrStb),
   .regRdStb(regRdStb), .regRdData(regRdData), .serialInPinOe(serialInPinOe),
   .serialOutPin(serialOutPin), .txIrq(txIrq), .rxIrq(rxIrq));
`default_nettype wire

/* tb/dsu_serial_peer.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// remote peer: frame sender and line sampler
module dsu_serial_peer (
   // clock
   input  wire logic        clock,
   // lines
   input  wire logic [1:0]  lineFromDut,
   input  wire logic [1:0]  dataFromDut,
   output logic      [1:0]  lineToDut,
   // captured bits
   output logic      [21:0] capBits,
   output logic             capValid
);
   initial begin
      lineToDut = 2'h3;
      capBits = 22'h000000;
      capValid = 1'b0;
   end
   // lsb first, then back to idle high
   task automatic send(input int ch, input logic [10:0] bits, input int n, input int bitClk);
      for (int i = 0; i < n; i++) begin
         lineToDut[ch] <= bits[i];
         repeat (bitClk) @(posedge clock);
      end
      lineToDut[ch] <= 1'b1;
   endtask
   // mode 0: one data bit per rising shift clock, lsb first
   task automatic capture0(input int ch, input int n);
      int k;
      k = 0;
      capBits = 22'h000000;
      for (int i = 0; i < n && k < 4000; i++) begin
         while (lineFromDut[ch] !== 1'b0 && k < 4000) begin
            @(posedge clock);
            k++;
         end
         while (lineFromDut[ch] !== 1'b1 && k < 4000) begin
            @(posedge clock);
            k++;
         end
         capBits[i] = dataFromDut[ch];
      end
      if (k >= 4000) capBits = {22{1'b1}};
      capValid <= 1'b1;
      @(posedge clock);
      capValid <= 1'b0;
   endtask
   // centres are sampled back to back, so an idle gap of half a bit or more shows as a wrong bit
   task automatic capture(input int ch, input int n, input int bitClk);
      int k;
      k = 0;
      while (lineFromDut[ch] !== 1'b0 && k < 4000) begin
         @(posedge clock);
         k++;
      end
      capBits = {22{k >= 4000}};
      if (k < 4000) begin
         repeat (bitClk / 2) @(posedge clock);
         for (int i = 0; i < n; i++) begin
            capBits[i] = lineFromDut[ch];
            if (i < n - 1) repeat (bitClk) @(posedge clock);
         end
      end
      capValid <= 1'b1;
      @(posedge clock);
      capValid <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* tb/dsu_dual_serial_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// self-checking bench of the dual serial block
module dsu_dual_serial_tb_top;
   import dsu_pkg::*;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic [3:0]  regAddr = 4'h0;
   logic [7:0]  regWrData = 8'h00;
   logic        regWrStb = 1'b0;
   logic        regRdStb = 1'b0;
   logic        timer1Ovf = 1'b0;
   logic        timer2Ovf = 1'b0;
   logic [1:0]  tmrCnt = 2'h0;
   logic        rdPend = 1'b0;
   logic [7:0]  regRdData;
   logic [1:0]  inOut;
   logic [1:0]  inOe;
   logic [1:0]  peerLine;
   logic [1:0]  rxWire;
   logic [1:0]  outPin;
   logic [1:0]  txIrq;
   logic [1:0]  rxIrq;
   logic [21:0] capBits;
   logic        capValid;
   logic [7:0]  rdQ [$];
   logic [21:0] frQ [$];
   int          error_cnt = 0;
   int          compares = 0;
   int          cCh [3] = '{0, 0, 1};
   int          cBit [3] = '{32, 32, 64};
   logic [1:0]  cMode [3] = '{2'h1, 2'h2, 2'h3};
   logic        cT9 [3] = '{1'b0, 1'b0, 1'b1};
   logic [7:0]  cSel [3] = '{8'h01, 8'h00, 8'h08};
   // mode 0 drive wins over the peer on the shared data line
   assign rxWire = (inOe & inOut) | (~inOe & peerLine);
   dsu_dual_serial dut (
      .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
      .timer1Ovf(timer1Ovf), .timer2Ovf(timer2Ovf), .serialInPin(rxWire),
      .serialInPinOut(inOut), .serialInPinOe(inOe), .serialOutPin(outPin),
      .txIrq(txIrq), .rxIrq(rxIrq));
   dsu_serial_peer peer (.clock(clock), .lineFromDut(outPin), .dataFromDut(rxWire),
      .lineToDut(peerLine),
      .capBits(capBits), .capValid(capValid));
   always #5 clock = ~clock;
   // timer1 ticks every 2 clocks, timer2 every 4, so their bit times differ
   always @(posedge clock) begin
      tmrCnt <= tmrCnt + 2'h1;
      timer1Ovf <= ~timer1Ovf;
      timer2Ovf <= (tmrCnt == 2'h3);
   end
   always @(posedge clock) begin
      rdPend <= regRdStb;
      if (rdPend) cmpRd(rdQ.pop_front(), regRdData);
      if (capValid) cmpFrame(frQ.pop_front(), capBits);
   end
   task automatic cmpRd(input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value read data expected %h seen %h", e, g);
      end
   endtask
   task automatic cmpFrame(input logic [21:0] e, input logic [21:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value serial frame expected %h seen %h", e, g);
      end
   endtask
   task automatic close_out();
      if (error_cnt == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      regRdStb <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      rdQ.push_back(e);
      regAddr <= a;
      regWrStb <= 1'b0;
      regRdStb <= 1'b1;
      @(posedge clock);
   endtask
   task automatic cyc(input int n);
      regWrStb <= 1'b0;
      regRdStb <= 1'b0;
      repeat (n) @(posedge clock);
   endtask
   task automatic waitRx();
      int k;
      for (k = 0; k < 2000 && rxIrq[1] !== 1'b1; k++) @(posedge clock);
      if (k == 2000) begin
         error_cnt++;
         close_out();
      end
   endtask
   function automatic logic [10:0] frm(input logic [7:0] d, input logic t9, input int n);
      return (n == 10) ? {2'h1, d, 1'b0} : {1'b1, t9, d, 1'b0};
   endfunction
   initial begin
      int         n;
      logic [3:0] base;
      logic [7:0] ctl;
      logic [7:0] d0;
      logic [7:0] d1;
      void'($urandom(32'h599EBD18));
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      rd(DSU_OFF_CTRL, 8'h00);
      rd(DSU_OFF_STAT + DSU_CHAN_STEP, 8'h00);
      rd(DSU_OFF_CLKSEL, 8'h00);
      rd(4'h3, 8'h00);
      rd(4'hC, 8'h00);
      for (int t = 0; t < 3; t++) begin
         base = (cCh[t] == 1) ? DSU_CHAN_STEP : 4'h0;
         n = (cMode[t] == 2'h1) ? 10 : 11;
         ctl = {cMode[t], 2'h0, cT9[t], 3'h0};
         d0 = 8'($urandom);
         d1 = 8'($urandom);
         frQ.push_back(22'(frm(d0, cT9[t], n)) | (22'(frm(d1, cT9[t], n)) << n));
         wr(DSU_OFF_CLKSEL, cSel[t]);
         wr(base + DSU_OFF_CTRL, ctl);
         fork
            peer.capture(cCh[t], 2 * n, cBit[t]);
            begin
               wr(base + DSU_OFF_BUF, d0);
               rd(base + DSU_OFF_CTRL, ctl | 8'h02);
               wr(base + DSU_OFF_BUF, d1);
               cyc(1);
            end
         join
         wr(base + DSU_OFF_CTRL, ctl);
         cyc(cBit[t]);
         rd(base + DSU_OFF_CTRL, ctl | 8'h02);
         cyc(1);
      end
      // mode 0 send on channel 0, then a reception of the idle-high line
      d0 = 8'($urandom);
      frQ.push_back(22'(d0));
      wr(DSU_OFF_CTRL, 8'h00);
      fork
         peer.capture0(0, 8);
         begin
            wr(DSU_OFF_BUF, d0);
            wr(DSU_OFF_CTRL, 8'h00);
            cyc(1);
         end
      join
      cyc(2);
      rd(DSU_OFF_CTRL, 8'h02);
      wr(DSU_OFF_CTRL, 8'h10);
      cyc(200);
      rd(DSU_OFF_BUF, 8'hFF);
      rd(DSU_OFF_CTRL, 8'h11);
      cyc(1);
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      wr(DSU_OFF_CLKSEL, 8'h00);
      wr(4'h4, 8'h40);
      cyc(1);
      peer.send(1, frm(d0, 1'b0, 10), 10, 32);
      cyc(32);
      rd(4'h4, 8'h40);
      wr(4'h4, 8'h50);
      cyc(1);
      peer.send(1, frm(d0, 1'b0, 10), 10, 32);
      waitRx();
      rd(4'h6, d0);
      rd(4'h4, 8'h55);
      cyc(1);
      peer.send(1, frm(d1, 1'b0, 10), 10, 32);
      cyc(4);
      rd(4'h5, 8'h03);
      rd(4'h6, d0);
      wr(4'h4, 8'h50);
      wr(4'h5, 8'h00);
      rd(4'h5, 8'h00);
      cyc(1);
      peer.send(1, 11'h000, 10, 32);
      cyc(4);
      rd(4'h5, 8'h0D);
      wr(4'h5, 8'h00);
      rd(4'h5, 8'h00);
      cyc(2);
      close_out();
   end
endmodule
`default_nettype wire
